// File: rtl/sbt_channel.v
// Purpose: per-channel bit error tester around one serial transceiver channel
// Assumes: fabric data path runs on i_clock, 32-bit words
// Notes: ratio is error count over bit count as a 32-bit binary fraction
// Contract
// - an injection request flips exactly one bit of one transmitted word, except in far fabric loop where it has no effect
// - generator and checker each select prbs7/15/23/31, clock 2x or 10x
// - count every received bit until counters are cleared
// - count every mismatching bit until counters are cleared
// - counter clear zeroes both counts; host clears after link settles
// - report error ratio from error count over bit count
// - loopback none uses no feedback path
// - near coding loop returns tx fabric data to rx fabric before analog
// - near analog loop turns data around after the analog layer
// - far analog loop returns rx pins straight to tx pins
// - far coding loop turns received data around after the coding layer
// - far fabric loop sends received data through a shallow fifo back out
// - channel reset clears coding, analog and fabric interface logic
// - tx polarity bit inverts all transmitted data
// - rx polarity bit inverts received data before checking
// - report linked or not locked, with measured line rate when linked
// - expose tx pll and rx pll lock states separately
// - measure tx output and user clock frequencies in mhz
// - drive swing, pre-emphasis, equalisation, ac coupling, termination controls
// - host reads and writes every reconfiguration address, applied at once
// - exposed ports are read-only or writable, writes applied at once
`timescale 1ns/1ns
`include "sbt_consts.vh"
module sbt_channel #(
    parameter FREQ_WINDOW = `SBT_FREQ_WINDOW,
    parameter CNT_W = 48
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire [2:0] i_tx_pattern,
    input wire [2:0] i_rx_pattern,
    input wire i_error_inject,
    input wire i_error_counter_clear,
    input wire [2:0] i_loopback,
    input wire i_channel_reset,
    input wire i_tx_invert,
    input wire i_rx_invert,
    input wire [3:0] i_tx_swing,
    input wire [3:0] i_tx_preemph,
    input wire [3:0] i_rx_equal,
    input wire i_rx_ac_couple,
    input wire [1:0] i_rx_term_sel,
    input wire [31:0] i_rx_word,
    input wire i_rx_valid,
    input wire i_tx_pll_lock,
    input wire i_rx_pll_lock,
    input wire i_tx_output_clock,
    input wire i_tx_user_clock,
    input wire i_tx_user_clock_half,
    input wire i_rx_user_clock,
    input wire i_rx_user_clock_half,
    input wire [15:0] i_line_rate,
    input wire i_drp_req,
    input wire i_drp_write,
    input wire [8:0] i_drp_addr,
    input wire [15:0] i_drp_wdata,
    output wire o_drp_en,
    output wire o_drp_we,
    output wire [8:0] o_drp_addr,
    output wire [15:0] o_drp_di,
    input wire [15:0] i_drp_do,
    input wire i_drp_rdy,
    output reg [15:0] o_drp_rdata,
    output reg o_drp_done,
    output reg [31:0] o_tx_word,
    output wire [2:0] o_xcvr_loopback,
    output wire o_xcvr_tx_invert,
    output wire o_xcvr_rx_invert,
    output wire o_xcvr_reset,
    output wire [3:0] o_tx_swing,
    output wire [3:0] o_tx_preemph,
    output wire [3:0] o_rx_equal,
    output wire o_rx_ac_couple,
    output wire [1:0] o_rx_term_sel,
    output reg [CNT_W-1:0] o_bit_count,
    output reg [CNT_W-1:0] o_err_count,
    output reg [31:0] o_err_ratio,
    output wire o_link_detect_state,
    output wire [15:0] o_link_rate,
    output wire o_tx_pll_locked,
    output wire o_rx_pll_locked,
    output wire [15:0] o_mhz_tx_output,
    output wire [15:0] o_mhz_tx_user,
    output wire [15:0] o_mhz_tx_user_half,
    output wire [15:0] o_mhz_rx_user,
    output wire [15:0] o_mhz_rx_user_half
);
    // ==========================================
    // pattern functions
    function [31:0] lfsr_step;
        input [2:0] pat;
        input [30:0] st;
        reg [30:0] s;
        reg b;
        integer i;
        begin
            s = st;
            b = 1'b0;
            lfsr_step = 32'h0;
            for (i = 31; i >= 0; i = i - 1) begin
                case (pat)
                    `SBT_PAT_PRBS7: b = s[6] ^ s[5];
                    `SBT_PAT_PRBS15: b = s[14] ^ s[13];
                    `SBT_PAT_PRBS23: b = s[22] ^ s[17];
                    default: b = s[30] ^ s[27];
                endcase
                lfsr_step[i] = b;
                s = {s[29:0], b};
            end
        end
    endfunction
    function [31:0] clk_word;
        input [2:0] pat;
        input [4:0] ph;
        begin
            if (pat == `SBT_PAT_CLK2X) begin
                clk_word = 32'haaaaaaaa;
            end else begin
                clk_word = {32{ph[0]}} ^ 32'hffc007fe;
            end
        end
    endfunction
    function [5:0] popcount;
        input [31:0] w;
        integer i;
        begin
            popcount = 6'h0;
            for (i = 0; i < 32; i = i + 1) begin
                popcount = popcount + {5'h0, w[i]};
            end
        end
    endfunction
    // ==========================================
    // channel reset sequencer
    reg [4:0] rst_cnt;
    wire chan_rst = (rst_cnt != 5'h0);
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_cnt <= 5'h0;
        end else if (i_channel_reset) begin
            rst_cnt <= `SBT_RESET_CYCLES;
        end else if (chan_rst) begin
            rst_cnt <= rst_cnt - 5'h1;
        end
    end
    assign o_xcvr_reset = chan_rst;
    // ==========================================
    // loopback, analog and polarity controls, pll lock status
    assign o_xcvr_loopback = i_loopback;
    assign o_xcvr_tx_invert = i_tx_invert;
    assign o_xcvr_rx_invert = i_rx_invert;
    assign o_tx_swing = i_tx_swing;
    assign o_tx_preemph = i_tx_preemph;
    assign o_rx_equal = i_rx_equal;
    assign o_rx_ac_couple = i_rx_ac_couple;
    assign o_rx_term_sel = i_rx_term_sel;
    assign o_tx_pll_locked = i_tx_pll_lock;
    assign o_rx_pll_locked = i_rx_pll_lock;
    // ==========================================
    // transmit generator
    reg [30:0] tx_state;
    reg [4:0] tx_phase;
    reg [31:0] fifo [0:3];
    reg [1:0] fifo_wp;
    reg [1:0] fifo_rp;
    wire tx_is_clk = (i_tx_pattern == `SBT_PAT_CLK2X) || (i_tx_pattern == `SBT_PAT_CLK10X);
    wire [31:0] tx_gen = tx_is_clk ? clk_word(i_tx_pattern, tx_phase)
        : lfsr_step(i_tx_pattern, tx_state);
    wire [31:0] tx_inj = tx_gen ^ {31'h0, i_error_inject};
    wire far_fabric = (i_loopback == `SBT_LB_FAR_FABRIC);
    wire [31:0] rx_pol = i_rx_invert ? ~i_rx_word : i_rx_word;
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_state <= 31'h7fffffff;
            tx_phase <= 5'h0;
            o_tx_word <= 32'h0;
            fifo_wp <= 2'h0;
            fifo_rp <= 2'h0;
        end else if (chan_rst) begin
            tx_state <= 31'h7fffffff;
            tx_phase <= 5'h0;
            o_tx_word <= 32'h0;
            fifo_wp <= 2'h0;
            fifo_rp <= 2'h0;
        end else begin
            tx_phase <= tx_phase + 5'h1;
            if (far_fabric) begin
                if (i_rx_valid) begin
                    fifo[fifo_wp] <= rx_pol;
                    fifo_wp <= fifo_wp + 2'h1;
                end
                if (fifo_wp != fifo_rp) begin
                    o_tx_word <= fifo[fifo_rp];
                    fifo_rp <= fifo_rp + 2'h1;
                end
            end else begin
                // other loop modes turn around inside the transceiver
                tx_state <= tx_gen[30:0];
                o_tx_word <= tx_inj;
            end
        end
    end
    // ==========================================
    // receive checker
    reg [30:0] rx_state;
    reg [4:0] rx_phase;
    wire rx_is_clk = (i_rx_pattern == `SBT_PAT_CLK2X) || (i_rx_pattern == `SBT_PAT_CLK10X);
    wire [31:0] rx_exp = rx_is_clk ? clk_word(i_rx_pattern, rx_phase)
        : lfsr_step(i_rx_pattern, rx_state);
    wire [5:0] errs = popcount(rx_pol ^ rx_exp);
    wire [CNT_W-1:0] max_cnt = {CNT_W{1'b1}};
    wire [CNT_W:0] next_bits = {1'b0, o_bit_count} + 33'd32;
    wire [CNT_W:0] next_errs = {1'b0, o_err_count} + {{(CNT_W-5){1'b0}}, errs};
    // free-run once linked so one flipped bit counts as one error
    wire [30:0] next_rx_state = o_link_detect_state ? rx_exp[30:0] : rx_pol[30:0];
    wire [4:0] next_rx_phase = o_link_detect_state ? rx_phase + 5'h1
        : {4'h0, rx_pol == clk_word(i_rx_pattern, 5'h0)};
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_state <= 31'h7fffffff;
            rx_phase <= 5'h0;
            o_bit_count <= {CNT_W{1'b0}};
            o_err_count <= {CNT_W{1'b0}};
        end else if (i_error_counter_clear || chan_rst) begin
            o_bit_count <= {CNT_W{1'b0}};
            o_err_count <= {CNT_W{1'b0}};
            rx_state <= next_rx_state;
            rx_phase <= next_rx_phase;
        end else if (i_rx_valid) begin
            rx_phase <= next_rx_phase;
            rx_state <= next_rx_state;
            o_bit_count <= next_bits[CNT_W] ? max_cnt : next_bits[CNT_W-1:0];
            o_err_count <= next_errs[CNT_W] ? max_cnt : next_errs[CNT_W-1:0];
        end
    end
    // ==========================================
    // error ratio, restoring division one bit per cycle
    reg [5:0] div_step;
    reg [CNT_W:0] rem;
    reg [31:0] quo;
    reg [CNT_W-1:0] den;
    wire [CNT_W:0] shifted = {rem[CNT_W-1:0], 1'b0};
    wire take = shifted >= {1'b0, den};
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_step <= 6'h0;
            rem <= {(CNT_W+1){1'b0}};
            quo <= 32'h0;
            den <= {CNT_W{1'b0}};
            o_err_ratio <= 32'h0;
        end else if (div_step == 6'h0) begin
            rem <= {1'b0, o_err_count};
            den <= o_bit_count;
            quo <= 32'h0;
            div_step <= 6'h20;
        end else begin
            rem <= take ? shifted - {1'b0, den} : shifted;
            quo <= {quo[30:0], take};
            div_step <= div_step - 6'h1;
            if (div_step == 6'h1) begin
                o_err_ratio <= (den == {CNT_W{1'b0}}) ? 32'h0 : {quo[30:0], take};
            end
        end
    end
    // ==========================================
    // link detection
    reg [4:0] good_run;
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            good_run <= 5'h0;
        end else if (chan_rst || !i_rx_pll_lock) begin
            good_run <= 5'h0;
        end else if (i_rx_valid) begin
            if (errs != 6'h0) begin
                good_run <= 5'h0;
            end else if (good_run != `SBT_LINK_GOOD) begin
                good_run <= good_run + 5'h1;
            end
        end
    end
    assign o_link_detect_state = (good_run == `SBT_LINK_GOOD);
    assign o_link_rate = o_link_detect_state ? i_line_rate : 16'h0;
    // ==========================================
    // dynamic reconfiguration port access
    reg drp_busy;
    assign o_drp_en = i_drp_req && !drp_busy;
    assign o_drp_we = i_drp_write;
    assign o_drp_addr = i_drp_addr;
    assign o_drp_di = i_drp_wdata;
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            drp_busy <= 1'b0;
            o_drp_rdata <= 16'h0;
            o_drp_done <= 1'b0;
        end else begin
            o_drp_done <= 1'b0;
            if (o_drp_en) begin
                drp_busy <= 1'b1;
            end else if (drp_busy && i_drp_rdy) begin
                drp_busy <= 1'b0;
                o_drp_done <= 1'b1;
                o_drp_rdata <= i_drp_do;
            end
        end
    end
    // ==========================================
    // clock frequency meters
    sbt_freq_meter #(.WINDOW(FREQ_WINDOW), .REF_MHZ(`SBT_REF_MHZ)) u_m0 (
        .i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_meas_clock(i_tx_output_clock), .o_mhz(o_mhz_tx_output));
    sbt_freq_meter #(.WINDOW(FREQ_WINDOW), .REF_MHZ(`SBT_REF_MHZ)) u_m1 (
        .i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_meas_clock(i_tx_user_clock), .o_mhz(o_mhz_tx_user));
    sbt_freq_meter #(.WINDOW(FREQ_WINDOW), .REF_MHZ(`SBT_REF_MHZ)) u_m2 (
        .i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_meas_clock(i_tx_user_clock_half), .o_mhz(o_mhz_tx_user_half));
    sbt_freq_meter #(.WINDOW(FREQ_WINDOW), .REF_MHZ(`SBT_REF_MHZ)) u_m3 (
        .i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_meas_clock(i_rx_user_clock), .o_mhz(o_mhz_rx_user));
    sbt_freq_meter #(.WINDOW(FREQ_WINDOW), .REF_MHZ(`SBT_REF_MHZ)) u_m4 (
        .i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_meas_clock(i_rx_user_clock_half), .o_mhz(o_mhz_rx_user_half));
endmodule

// File: rtl/sbt_consts.vh
// Purpose: constants for the serial channel bit error tester
// Assumes: one channel per instance
// Notes: definitions only
`ifndef SBT_CONSTS_VH
`define SBT_CONSTS_VH
// ==========================================
// pattern select codes
`define SBT_PAT_PRBS7 3'h0
`define SBT_PAT_PRBS15 3'h1
`define SBT_PAT_PRBS23 3'h2
`define SBT_PAT_PRBS31 3'h3
`define SBT_PAT_CLK2X 3'h4
`define SBT_PAT_CLK10X 3'h5
// ==========================================
// loopback select codes
`define SBT_LB_NONE 3'h0
`define SBT_LB_NEAR_CODING 3'h1
`define SBT_LB_NEAR_ANALOG 3'h2
`define SBT_LB_FAR_ANALOG 3'h3
`define SBT_LB_FAR_CODING 3'h4
`define SBT_LB_FAR_FABRIC 3'h5
// ==========================================
// timing
`define SBT_REF_MHZ 250
`define SBT_FREQ_WINDOW 250000
`define SBT_RESET_CYCLES 5'h10
`define SBT_LINK_GOOD 5'h10
`endif

// File: rtl/sbt_freq_meter.v
// Purpose: measures one clock against the reference clock
// Assumes: measured clock below four times the reference rate
// Notes: gray-coded counter crosses into the reference domain
`timescale 1ns/1ns
module sbt_freq_meter #(
    parameter WINDOW = 250000,
    parameter REF_MHZ = 250
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_meas_clock,
    output reg [15:0] o_mhz
);
    // ==========================================
    // measured domain counter
    reg [23:0] meas_bin;
    reg [23:0] meas_gray;
    always @(posedge i_meas_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meas_bin <= 24'h0;
            meas_gray <= 24'h0;
        end else begin
            meas_bin <= meas_bin + 24'h1;
            meas_gray <= (meas_bin >> 1) ^ meas_bin;
        end
    end
    // ==========================================
    // crossing and windowing
    reg [23:0] sync_a;
    reg [23:0] sync_b;
    reg [23:0] last;
    reg [31:0] win;
    reg [23:0] bin;
    integer k;
    always @* begin
        bin = 24'h0;
        bin[23] = sync_b[23];
        for (k = 22; k >= 0; k = k - 1) begin
            bin[k] = bin[k + 1] ^ sync_b[k];
        end
    end
    wire [23:0] delta = bin - last;
    wire [47:0] scaled = delta * REF_MHZ;
    wire [47:0] mhz_full = scaled / WINDOW;
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_a <= 24'h0;
            sync_b <= 24'h0;
            last <= 24'h0;
            win <= 32'h0;
            o_mhz <= 16'h0;
        end else begin
            sync_a <= meas_gray;
            sync_b <= sync_a;
            if (win == WINDOW - 1) begin
                win <= 32'h0;
                last <= bin;
                o_mhz <= mhz_full[15:0];
            end else begin
                win <= win + 32'h1;
            end
        end
    end
endmodule

// File: verif/sbt_channel_asserts.sv
// Purpose: port-level checks of one bit error tester channel
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to sbt_channel from tb_top
`timescale 1ns/1ns
module sbt_channel_asserts #(
    parameter CNT_W = 48
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_error_counter_clear,
    input wire [2:0] i_loopback,
    input wire i_channel_reset,
    input wire i_tx_invert,
    input wire i_rx_invert,
    input wire i_rx_valid,
    input wire i_tx_pll_lock,
    input wire i_rx_pll_lock,
    input wire [15:0] i_line_rate,
    input wire i_drp_rdy,
    input wire o_drp_done,
    input wire [2:0] o_xcvr_loopback,
    input wire o_xcvr_tx_invert,
    input wire o_xcvr_rx_invert,
    input wire o_xcvr_reset,
    input wire [CNT_W-1:0] o_bit_count,
    input wire [CNT_W-1:0] o_err_count,
    input wire o_link_detect_state,
    input wire [15:0] o_link_rate,
    input wire o_tx_pll_locked,
    input wire o_rx_pll_locked
);
    localparam [CNT_W-1:0] MAXC = {CNT_W{1'b1}};
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    sequence s_rst_eight;
        o_xcvr_reset [*8];
    endsequence
    // ==========================================
    // counters
    a_bits_step: assert property (i_rx_valid && !i_error_counter_clear && !i_channel_reset
        && !o_xcvr_reset && o_bit_count < MAXC - 32 |=> o_bit_count == $past(o_bit_count) + 32)
        else $error("bit count did not step by one word");
    a_clear_zero: assert property (i_error_counter_clear |=>
        o_bit_count == 0 && o_err_count == 0) else $error("counter clear missed");
    a_err_bound: assert property (o_err_count <= o_bit_count)
        else $error("error count above bit count");
    // ==========================================
    // pass-through controls and status
    a_loop_pass: assert property (o_xcvr_loopback == i_loopback)
        else $error("loopback select not driven");
    a_pol_pass: assert property ({o_xcvr_tx_invert, o_xcvr_rx_invert} ==
        {i_tx_invert, i_rx_invert}) else $error("polarity select not driven");
    a_pll_pass: assert property ({o_tx_pll_locked, o_rx_pll_locked} ==
        {i_tx_pll_lock, i_rx_pll_lock}) else $error("pll lock status wrong");
    a_link_rate: assert property (o_link_rate == (o_link_detect_state ? i_line_rate : 16'h0))
        else $error("line rate shown while not linked");
    // ==========================================
    // channel reset and config port
    a_rst_len: assert property ($rose(o_xcvr_reset) |->
        s_rst_eight ##1 s_rst_eight ##1 !o_xcvr_reset) else $error("channel reset length wrong");
    a_drp_done: assert property (o_drp_done == $past(i_drp_rdy))
        else $error("config done not one cycle after ready");
endmodule

// File: verif/sbt_xcvr_model.sv
// Purpose: remote endpoint and transceiver config port model
// Assumes: endpoint echoes transmitted words while enabled
// Notes: config answer latency alternates short and long
`timescale 1ns/1ns
module sbt_xcvr_model (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_echo,
    input wire [31:0] i_tx_word,
    input wire i_drp_en,
    input wire i_drp_we,
    input wire [8:0] i_drp_addr,
    input wire [15:0] i_drp_di,
    output wire o_rx_valid,
    output wire [31:0] o_rx_word,
    output reg o_drp_rdy,
    output wire [15:0] o_drp_do
);
    reg [15:0] mem [0:511];
    reg [8:0] addr;
    reg [2:0] cnt;
    reg slow;
    integer k;
    initial begin
        for (k = 0; k < 512; k = k + 1) begin
            mem[k] = ~k[15:0];
        end
    end
    // ==========================================
    // echo path, released data shows the inverse
    assign o_rx_valid = i_echo;
    assign o_rx_word = i_echo ? i_tx_word : ~i_tx_word;
    // ==========================================
    // config port
    assign o_drp_do = o_drp_rdy ? mem[addr] : ~mem[addr];
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= 3'h0;
            o_drp_rdy <= 1'b0;
            slow <= 1'b0;
            addr <= 9'h0;
        end else begin
            o_drp_rdy <= 1'b0;
            if (i_drp_en) begin
                addr <= i_drp_addr;
                cnt <= slow ? 3'h5 : 3'h1;
                slow <= ~slow;
                if (i_drp_we) begin
                    mem[i_drp_addr] <= i_drp_di;
                end
            end else if (cnt == 3'h1) begin
                o_drp_rdy <= 1'b1;
                cnt <= 3'h0;
            end else if (cnt != 3'h0) begin
                cnt <= cnt - 3'h1;
            end
        end
    end
endmodule

// File: verif/tb_top.sv
// Purpose: self-checking bench for sbt_channel
// Assumes: measurement window cut to 256 cycles
// Notes: remote end echoes transmitted words
`timescale 1ns/1ns
module tb_top;
    reg i_clock = 1'b0;
    reg i_rst_b = 1'b0;
    reg [2:0] tp = 3'h0;
    reg inj = 1'b0;
    reg clr = 1'b0;
    reg chr = 1'b0;
    reg echo = 1'b1;
    reg req = 1'b0;
    reg wr = 1'b0;
    reg [8:0] da = 9'h0;
    reg [15:0] dw = 16'h0;
    reg [15:0] rate = 16'h1388;
    reg [3:0] mc = 4'h0;
    reg [21:0] pin = 22'h0;
    reg [21:0] rows [0:5];
    reg [15:0] q;
    integer err_total = 0;
    integer cmp_count = 0;
    integer i;
    integer n;
    wire [31:0] rxw, txw, ratio;
    wire [47:0] bits, errs;
    wire [21:0] po;
    wire [15:0] ddi, ddo, drd, lrate, m0, m1, m2, m3, m4;
    wire [8:0] dad;
    wire rxv, den, dwe, drdy, ddone, xrst, link;
    always #2 i_clock = ~i_clock;
    always #4 mc[0] = ~mc[0];
    always #8 mc[1] = ~mc[1];
    always #5 mc[2] = ~mc[2];
    always #10 mc[3] = ~mc[3];
    sbt_channel #(.FREQ_WINDOW(256)) DUT (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_tx_pattern(tp), .i_rx_pattern(tp), .i_error_inject(inj), .i_error_counter_clear(clr),
        .i_loopback(pin[21:19]), .i_channel_reset(chr), .i_tx_invert(pin[18]),
        .i_rx_invert(pin[17]), .i_tx_swing(pin[16:13]), .i_tx_preemph(pin[12:9]),
        .i_rx_equal(pin[8:5]), .i_rx_ac_couple(pin[4]), .i_rx_term_sel(pin[3:2]),
        .i_rx_word(rxw), .i_rx_valid(rxv), .i_tx_pll_lock(pin[1]), .i_rx_pll_lock(pin[0]),
        .i_tx_output_clock(mc[0]), .i_tx_user_clock(mc[0]), .i_tx_user_clock_half(mc[1]),
        .i_rx_user_clock(mc[2]), .i_rx_user_clock_half(mc[3]), .i_line_rate(rate),
        .i_drp_req(req), .i_drp_write(wr), .i_drp_addr(da), .i_drp_wdata(dw), .o_drp_en(den),
        .o_drp_we(dwe), .o_drp_addr(dad), .o_drp_di(ddi), .i_drp_do(ddo), .i_drp_rdy(drdy),
        .o_drp_rdata(drd), .o_drp_done(ddone), .o_tx_word(txw), .o_xcvr_loopback(po[21:19]),
        .o_xcvr_tx_invert(po[18]), .o_xcvr_rx_invert(po[17]), .o_xcvr_reset(xrst),
        .o_tx_swing(po[16:13]), .o_tx_preemph(po[12:9]), .o_rx_equal(po[8:5]),
        .o_rx_ac_couple(po[4]), .o_rx_term_sel(po[3:2]), .o_bit_count(bits), .o_err_count(errs),
        .o_err_ratio(ratio), .o_link_detect_state(link), .o_link_rate(lrate),
        .o_tx_pll_locked(po[1]), .o_rx_pll_locked(po[0]), .o_mhz_tx_output(m0),
        .o_mhz_tx_user(m1), .o_mhz_tx_user_half(m2), .o_mhz_rx_user(m3), .o_mhz_rx_user_half(m4));
    // far end inverts while rx invert is set, so a working inverter restores clean data
    sbt_xcvr_model u_far (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_echo(echo),
        .i_tx_word(pin[17] ? ~txw : txw),
        .i_drp_en(den), .i_drp_we(dwe), .i_drp_addr(dad), .i_drp_di(ddi), .o_rx_valid(rxv),
        .o_rx_word(rxw), .o_drp_rdy(drdy), .o_drp_do(ddo));
    // ==========================================
    // shared tasks
    task chk(input [47:0] exp, input [47:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (exp !== got) begin
                err_total = err_total + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task chk_near(input [15:0] exp, input [15:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (((got + 16'h2 - exp) <= 16'h4) !== 1'b1) begin
                err_total = err_total + 1;
                $display("[ERR] %0t mhz %0d expected about %0d", $time, got, exp);
            end
        end
    endtask
    task tick(input integer k);
        repeat (k) @(posedge i_clock);
    endtask
    task clear_counts;
        begin
            clr <= 1'b1;
            tick(1);
            clr <= 1'b0;
        end
    endtask
    task dynamic_reconfig_port(input w, input [8:0] a, input [15:0] d);
        begin
            @(posedge i_clock);
            req <= 1'b1;
            wr <= w;
            da <= a;
            dw <= d;
            n = 0;
            @(posedge i_clock);
            while (den !== 1'b1 && n < 20) begin
                @(posedge i_clock);
                n = n + 1;
            end
            req <= 1'b0;
            while (ddone !== 1'b1 && n < 40) begin
                @(posedge i_clock);
                n = n + 1;
            end
            q = drd;
            chk(48'h1, ddone);
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // ==========================================
    // tests
    initial begin
        rows[0] = 22'h000000;
        rows[1] = 22'h0fffff;
        rows[2] = 22'h12a5a6;
        rows[3] = 22'h1d5a59;
        rows[4] = 22'h233333;
        rows[5] = 22'h2ccccc;
        tick(3);
        i_rst_b <= 1'b1;
        @(negedge i_clock);
        chk(48'h0, bits | {46'h0, ddone, xrst});
        for (i = 0; i < 6; i = i + 1) begin
            @(posedge i_clock);
            pin <= rows[i];
            @(negedge i_clock);
            chk(rows[i], po);
        end
        @(posedge i_clock);
        pin <= 22'h000003;
        $display("test pins done");
        for (i = 0; i < 6; i = i + 1) begin
            @(posedge i_clock);
            tp <= i[2:0];
            tick(40);
            clear_counts;
            tick(32);
            @(negedge i_clock);
            chk(48'h0, errs);
        end
        chk({1'b1, rate}, {link, lrate});
        $display("test patterns done");
        @(posedge i_clock);
        tp <= 3'h0;
        tick(40);
        clear_counts;
        tick(19);
        inj <= 1'b1;
        tick(1);
        inj <= 1'b0;
        tick(44);
        echo <= 1'b0;
        tick(40);
        @(negedge i_clock);
        chk(48'd2048, bits);
        chk(48'h1, errs);
        chk(48'h00200000, ratio);
        $display("test inject done");
        @(posedge i_clock);
        pin <= 22'h020003;
        echo <= 1'b1;
        tick(8);
        clear_counts;
        tick(16);
        echo <= 1'b0;
        tick(4);
        @(negedge i_clock);
        chk(48'd512, bits);
        chk(48'h0, errs);
        chk({1'b1, rate}, {link, lrate});
        $display("test rx invert done");
        @(posedge i_clock);
        pin <= 22'h000003;
        chr <= 1'b1;
        tick(1);
        chr <= 1'b0;
        n = 0;
        for (i = 0; i < 40; i = i + 1) begin
            @(negedge i_clock);
            if (xrst === 1'b1)
                n = n + 1;
        end
        chk(48'd16, n);
        chk(48'h0, {link, lrate});
        $display("test channel reset done");
        dynamic_reconfig_port(1'b1, 9'h000, 16'h1234);
        dynamic_reconfig_port(1'b1, 9'h1ff, 16'hbeef);
        dynamic_reconfig_port(1'b0, 9'h000, 16'h0);
        chk(16'h1234, q);
        dynamic_reconfig_port(1'b0, 9'h1ff, 16'h0);
        chk(16'hbeef, q);
        dynamic_reconfig_port(1'b0, 9'h0a5, 16'h0);
        chk(16'hff5a, q);
        $display("test config port done");
        chk_near(16'd125, m0);
        chk_near(16'd125, m1);
        chk_near(16'd62, m2);
        chk_near(16'd100, m3);
        chk_near(16'd50, m4);
        $display("test clock meters done");
        report_and_stop;
    end
    initial begin
        #40000;
        err_total = err_total + 1;
        report_and_stop;
    end
endmodule
bind sbt_channel sbt_channel_asserts #(.CNT_W(CNT_W)) u_chk (.i_clock(i_clock),
    .i_rst_b(i_rst_b), .i_error_counter_clear(i_error_counter_clear), .i_loopback(i_loopback),
    .i_channel_reset(i_channel_reset), .i_tx_invert(i_tx_invert), .i_rx_invert(i_rx_invert),
    .i_rx_valid(i_rx_valid), .i_tx_pll_lock(i_tx_pll_lock), .i_rx_pll_lock(i_rx_pll_lock),
    .i_line_rate(i_line_rate), .i_drp_rdy(i_drp_rdy), .o_drp_done(o_drp_done),
    .o_xcvr_loopback(o_xcvr_loopback), .o_xcvr_tx_invert(o_xcvr_tx_invert),
    .o_xcvr_rx_invert(o_xcvr_rx_invert), .o_xcvr_reset(o_xcvr_reset),
    .o_bit_count(o_bit_count), .o_err_count(o_err_count),
    .o_link_detect_state(o_link_detect_state), .o_link_rate(o_link_rate),
    .o_tx_pll_locked(o_tx_pll_locked), .o_rx_pll_locked(o_rx_pll_locked));
